// file: pclut_top.sv
// Pseudo-colour look-up table pixel output path with host load port
`timescale 1ns/1ps
// Function
// R1: Top address bit selects the overlay half
// R2: Cursor forces group three, others disabled
// R3: Cursor group inputs wired to constant address
// R4: Software fills 128..255 for overlay cursor
// R5: Table address is ten bits, 1024 entries
// R6: Bits eight, nine shared, not channel switched
// R7: Entry is blue, green, red nibbles
// R8: Sixteen levels per colour, all-ones white
// R9: Source select bits pick plane group
// R10: Data write steps counter by direction
// R11: Load-enable routes counter, blanks video
// R12: Host loads table then clears load-enable
// R13: Low address control, high address data
// R14: Three-stage pipeline, sync delayed to match
// R15: Text overlay forces white over everything
// R16: Reset clears address register
module pclut_top (
   input  wire logic                               clk,
   input  wire logic                               rst,
   input  wire logic                               host_sel,
   input  wire logic                               host_wr,
   input  wire logic                               host_rd,
   input  wire logic [pclut_pkg::HOST_W-1:0]       host_wdata,
   output logic                                    host_wr_ready,
   output logic      [pclut_pkg::HOST_W-1:0]       host_rdata,
   output logic                                    host_rvalid,
   input  wire logic [pclut_pkg::PLANE_W-1:0]      plane_grp0,
   input  wire logic [pclut_pkg::PLANE_W-1:0]      plane_grp1,
   input  wire logic [pclut_pkg::PLANE_W-1:0]      plane_grp2,
   input  wire logic [pclut_pkg::PLANE_W-1:0]      plane_grp3,
   input  wire logic                               shared_addr_bit_eight,
   input  wire logic                               shared_addr_bit_nine,
   input  wire logic                               cursor_in,
   input  wire logic                               text_overlay_in,
   input  wire logic                               ext_blank_in,
   input  wire logic                               mixed_sync_in,
   output logic      [pclut_pkg::COLOUR_W-1:0]     colour_out,
   output logic      [3:0]                         red_out,
   output logic      [3:0]                         green_out,
   output logic      [3:0]                         blue_out,
   output logic                                    mixed_sync_out
);
   import pclut_pkg::*;

   // Host-side state
   logic [1:0]            src_sel_r;
   logic                  count_direction_r;
   logic                  load_en_r;
   logic [LUT_AW-1:0]     cnt_r;
   logic [COLOUR_W-1:0]   lut_r [LUT_DEPTH];

   // Write buffer signals
   logic                  wb_out_valid;
   logic                  wb_out_ready;
   logic [WBUF_W-1:0]     wb_out_data;
   logic                  wb_pop;
   logic                  wb_is_data;
   logic [HOST_W-1:0]     wb_word;

   // Decoded buffer pops and next counter value
   logic                  pop_ctl;
   logic                  pop_data;
   logic [LUT_AW-1:0]     cnt_step;

   // Read-back words
   logic [HOST_W-1:0]     ctl_word;
   logic [HOST_W-1:0]     data_word;
   logic [COLOUR_W-1:0]   lut_rd_data;

   // Per-group selectors, packed so each slice has one driver
   logic [NUM_GROUPS-1:0][PLANE_W-1:0] plane_in;
   logic [NUM_GROUPS-1:0][PLANE_W-1:0] grp_masked;
   logic [NUM_GROUPS-1:0]              grp_en;
   logic [PLANE_W-1:0]                 grp_sel;

   // Pixel pipeline state
   logic [COLOUR_W-1:0]   colour_nxt;
   logic                  b8_r;
   logic                  b9_r;
   logic                  cursor_r;
   logic [LUT_AW-1:0]     pix_addr_r;
   logic [LUT_AW-1:0]     pix_addr_nxt;
   logic [1:0]            grp_pick;
   logic [COLOUR_W-1:0]   colour_r;
   logic [PIPE_LAT-1:0]   text_dly_r;
   logic [PIPE_LAT-1:0]   blank_dly_r;
   logic [PIPE_LAT-1:0]   sync_dly_r;

   // Host writes, both registers, go through the buffer in arrival order
   pclut_fifo #(
      .WIDTH (WBUF_W),
      .DEPTH (WBUF_DEPTH)
   ) u_wbuf (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (host_wr),
      .in_ready  (host_wr_ready),
      .in_data   ({host_sel, host_wdata}),
      .out_valid (wb_out_valid),
      .out_ready (wb_out_ready),
      .out_data  (wb_out_data)
   );

   // Reads win the table port; draining stalls for that cycle
   assign wb_out_ready = !host_rd;
   assign wb_pop       = wb_out_valid && wb_out_ready;
   assign wb_is_data   = wb_out_data[WBUF_W-1];  // R13
   assign wb_word      = wb_out_data[HOST_W-1:0];
   assign pop_ctl      = wb_pop && (wb_is_data == SEL_ADDR_REG);  // R13
   assign pop_data     = wb_pop && (wb_is_data == SEL_DATA_REG);  // R13

   // Source select: which plane group feeds the table when not loading
   always_ff @(posedge clk) begin
      if (rst) begin
         src_sel_r <= CTL_RESET[CTL_SRC_LSB +: 2];  // R16
      end else if (pop_ctl) begin
         src_sel_r <= wb_word[CTL_SRC_LSB +: 2];  // R9
      end
   end

   // Count direction, used by the next data write
   always_ff @(posedge clk) begin
      if (rst) begin
         count_direction_r <= CTL_RESET[CTL_DIR_BIT];
      end else if (pop_ctl) begin
         count_direction_r <= wb_word[CTL_DIR_BIT];  // R10
      end
   end

   // Load enable; clearing it on reset keeps the picture unblanked
   always_ff @(posedge clk) begin
      if (rst) begin
         load_en_r <= CTL_RESET[CTL_LOAD_BIT];  // R16
      end else if (pop_ctl) begin
         load_en_r <= wb_word[CTL_LOAD_BIT];  // R11
      end
   end

   // Next counter value for a data write; wraps modulo the table depth
   always_comb begin
      if (count_direction_r) begin
         cnt_step = cnt_r + 1'b1;  // R10
      end else begin
         cnt_step = cnt_r - 1'b1;  // R10
      end
   end

   // Auto-stepping table address counter; reads leave it alone
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= CNT_RESET;  // R16
      end else if (pop_ctl) begin
         cnt_r <= wb_word[CTL_ADDR_LSB +: LUT_AW];  // R5
      end else if (pop_data) begin
         cnt_r <= cnt_step;  // R10
      end
   end

   // Table storage, 12-bit colour words; step happens after the store
   always_ff @(posedge clk) begin
      if (pop_data) begin
         lut_r[cnt_r] <= wb_word[COLOUR_W-1:0];  // R7
      end
   end

   // Read-back words; unused address register bits read as zero
   assign lut_rd_data = lut_r[cnt_r];
   assign ctl_word    = {load_en_r, count_direction_r, src_sel_r, 2'h0, cnt_r};  // R13
   assign data_word   = {4'h0, lut_rd_data};  // R13

   // Read strobe answer, one cycle after the request
   always_ff @(posedge clk) begin
      if (rst) begin
         host_rvalid <= 1'b0;
      end else begin
         host_rvalid <= host_rd;
      end
   end

   // Read data holds until the next read; data reads never step
   always_ff @(posedge clk) begin
      if (rst) begin
         host_rdata <= '0;
      end else if (host_rd) begin
         if (host_sel == SEL_DATA_REG) begin
            host_rdata <= data_word;  // R10
         end else begin
            host_rdata <= ctl_word;
         end
      end
   end

   // Plane groups gathered so every selector is built alike
   assign plane_in[0] = plane_grp0;
   assign plane_in[1] = plane_grp1;
   assign plane_in[2] = plane_grp2;
   assign plane_in[3] = plane_grp3;  // R3

   // Group choice: cursor overrides the programmed selection
   assign grp_pick = cursor_r ? CURSOR_GROUP : src_sel_r;  // R2

   // Stage one per group: capture, then gate by the selector enable
   for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_sel
      logic [PLANE_W-1:0] cap_r;
      always_ff @(posedge clk) begin
         if (rst) begin
            cap_r <= '0;
         end else begin
            cap_r <= plane_in[g];  // R14
         end
      end
      // Only the enabled selector reaches the address bus
      assign grp_en[g]     = (grp_pick == 2'(g));  // R2 R9
      assign grp_masked[g] = grp_en[g] ? cap_r : '0;
   end

   // Selector outputs merge by OR, as at most one is enabled
   always_comb begin
      grp_sel = '0;
      for (int k = 0; k < NUM_GROUPS; k++) begin
         grp_sel = grp_sel | grp_masked[k];
      end
   end

   // Stage one: shared address bits and cursor
   always_ff @(posedge clk) begin
      if (rst) begin
         b8_r     <= 1'b0;
         b9_r     <= 1'b0;
         cursor_r <= 1'b0;
      end else begin
         b8_r     <= shared_addr_bit_eight;  // R6
         b9_r     <= shared_addr_bit_nine;   // R6
         cursor_r <= cursor_in;              // R14
      end
   end

   // Table address: counter while loading, else shared bits over chosen group
   always_comb begin
      if (load_en_r) begin
         pix_addr_nxt = cnt_r;  // R11
      end else begin
         // Bit seven of the group is the overlay bit in 8-bit use
         pix_addr_nxt = {b9_r, b8_r, grp_sel};  // R1 R6 R9
      end
   end

   // Stage two: register the table address
   always_ff @(posedge clk) begin
      if (rst) begin
         pix_addr_r <= '0;
      end else begin
         pix_addr_r <= pix_addr_nxt;  // R14
      end
   end

   // Text overlay rides a shift line so it meets its own pixel
   always_ff @(posedge clk) begin
      if (rst) begin
         text_dly_r <= '0;
      end else begin
         text_dly_r <= {text_dly_r[PIPE_LAT-2:0], text_overlay_in};  // R15
      end
   end

   // External blank delayed alike; an early blank would cut a live pixel
   always_ff @(posedge clk) begin
      if (rst) begin
         blank_dly_r <= '0;
      end else begin
         blank_dly_r <= {blank_dly_r[PIPE_LAT-2:0], ext_blank_in};
      end
   end

   // Mixed sync delayed the full pipeline depth to stay with the video
   always_ff @(posedge clk) begin
      if (rst) begin
         sync_dly_r <= '0;
      end else begin
         sync_dly_r <= {sync_dly_r[PIPE_LAT-2:0], mixed_sync_in};  // R14
      end
   end

   // Output priority: text white, then blanking, then the table word
   always_comb begin
      if (text_dly_r[PIPE_LAT-2]) begin
         colour_nxt = COLOUR_WHITE;  // R15 R8
      end else if (load_en_r || blank_dly_r[PIPE_LAT-2]) begin
         colour_nxt = COLOUR_BLACK;  // R11
      end else begin
         colour_nxt = lut_r[pix_addr_r];  // R14
      end
   end

   // Stage three: register the colour word
   always_ff @(posedge clk) begin
      if (rst) begin
         colour_r <= COLOUR_BLACK;
      end else begin
         colour_r <= colour_nxt;  // R14
      end
   end

   // Colour fields split out for the converters
   assign colour_out     = colour_r;
   assign red_out        = colour_r[RED_LSB +: 4];    // R7
   assign green_out      = colour_r[GREEN_LSB +: 4];  // R7
   assign blue_out       = colour_r[BLUE_LSB +: 4];   // R7
   assign mixed_sync_out = sync_dly_r[PIPE_LAT-1];
endmodule // pclut_top

// file: pclut_pkg.sv
// Shared constants for the pseudo-colour look-up table output path
package pclut_pkg;
   // Register select: low address picks the address register, high the data register
   localparam logic       SEL_ADDR_REG  = 1'b0;
   localparam logic       SEL_DATA_REG  = 1'b1;

   // Table geometry
   localparam int         LUT_AW        = 10;
   localparam int         LUT_DEPTH     = 1024;
   localparam int         COLOUR_W      = 12;
   localparam int         HOST_W        = 16;
   localparam int         PLANE_W       = 8;
   localparam int         NUM_GROUPS    = 4;

   // Address register field positions
   localparam int         CTL_ADDR_LSB  = 0;
   localparam int         CTL_SRC_LSB   = 12;
   localparam int         CTL_DIR_BIT   = 14;
   localparam int         CTL_LOAD_BIT  = 15;

   // Colour word field positions, four bits each
   localparam int         RED_LSB       = 0;
   localparam int         GREEN_LSB     = 4;
   localparam int         BLUE_LSB      = 8;

   // Reference colour values
   localparam logic [11:0] COLOUR_BLACK = 12'h000;
   localparam logic [11:0] PEAK_RED     = 12'h00F;
   localparam logic [11:0] PEAK_GREEN   = 12'h0F0;
   localparam logic [11:0] PEAK_BLUE    = 12'hF00;
   localparam logic [11:0] COLOUR_WHITE = 12'hFFF;

   // Group forced while the cursor is active
   localparam logic [1:0] CURSOR_GROUP  = 2'h3;

   // Reset values
   localparam logic [15:0] CTL_RESET    = 16'h0000;
   localparam logic [9:0]  CNT_RESET    = 10'h000;

   // Write buffer
   localparam int         WBUF_DEPTH    = 4;
   localparam int         WBUF_W        = 17;

   // Pixel pipeline latency in pixel clocks
   localparam int         PIPE_LAT      = 3;
endpackage

// file: pclut_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module pclut_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0]    wp_r;
   logic [PW-1:0]    rp_r;
   logic [PW:0]      cnt_r;
   logic             push;
   logic             pop;

   // Honest full and empty from the occupancy count
   assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_r[rp_r];

   // Storage, no reset needed on data
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   // Pointers wrap naturally at a power-of-two depth
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule // pclut_fifo

// file: pclut_monitor.sv
// Checker for the look-up table output path
`timescale 1ns/1ps
module pclut_monitor (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        host_rd,
   input wire logic        host_rvalid,
   input wire logic [15:0] host_rdata,
   input wire logic        host_wr_ready,
   input wire logic        text_overlay_in,
   input wire logic        ext_blank_in,
   input wire logic        mixed_sync_in,
   input wire logic        mixed_sync_out,
   input wire logic [11:0] colour_out,
   input wire logic [3:0]  red_out,
   input wire logic [3:0]  green_out,
   input wire logic [3:0]  blue_out
);
   logic [1:0] age_r;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Cycles since reset; pipeline history only trusted after three
   always_ff @(posedge clk) begin
      if (rst)
         age_r <= 2'h0;
      else if (age_r != 2'h3)
         age_r <= age_r + 2'h1;
   end
   slice_order_a: assert property (colour_out == {blue_out, green_out, red_out})
      else $error("colour slices disagree");
   sync_lag_a: assert property (age_r == 2'h3 |-> mixed_sync_out == $past(mixed_sync_in, 3))
      else $error("sync lag wrong");
   text_white_a: assert property (age_r == 2'h3 && $past(text_overlay_in, 3)
      |-> colour_out == 12'hFFF) else $error("text not white");
   blank_black_a: assert property (age_r == 2'h3 && $past(ext_blank_in, 3)
      && !$past(text_overlay_in, 3) |-> colour_out == 12'h000) else $error("blank not black");
   read_answer_a: assert property (host_rd |=> host_rvalid)
      else $error("read not answered");
   answer_cause_a: assert property (host_rvalid |-> $past(host_rd))
      else $error("answer without read");
   rdata_hold_a: assert property (!host_rvalid |-> $stable(host_rdata))
      else $error("read data moved");
   reset_clear_a: assert property ($fell(rst) |-> colour_out == 12'h000
      && !host_rvalid && host_wr_ready) else $error("reset state wrong");
endmodule // pclut_monitor

// file: pclut_planes.sv
// Frame store stand-in driving the four plane groups
`timescale 1ns/1ps
module pclut_planes #(
   parameter logic [7:0] CURSOR_ADDR = 8'hFF
) (
   input  wire logic       clk,
   input  wire logic [7:0] pat,
   output logic      [7:0] grp0,
   output logic      [7:0] grp1,
   output logic      [7:0] grp2,
   output logic      [7:0] grp3
);
   // Distinct views of one pattern so a wrong group shows
   always_ff @(posedge clk) begin
      grp0 <= pat;
      grp1 <= pat ^ 8'hA5;
      grp2 <= ~pat;
   end
   // Cursor group wired to one fixed table address
   assign grp3 = CURSOR_ADDR;
endmodule // pclut_planes

// file: tb_pclut_top.sv
// Self-checking bench for the look-up table output path
`timescale 1ns/1ps
module tb_pclut_top;
   import pclut_pkg::*;
   logic clk = 0, rst = 1, hsel = 0, hwr = 0, hrd = 0, b8 = 0, b9 = 0;
   logic cur = 0, txt = 0, blk = 0, syn = 0, wrdy, rv, so;
   logic [15:0] wd = 0, rdata, got;
   logic [7:0] pat = 0, g0, g1, g2, g3;
   logic [11:0] colour, shadow [LUT_DEPTH];
   logic [3:0] r_o, gr_o, b_o;
   int err_count, cmp_count, seed = 94, cyc, i, n;
   pclut_planes u_pclut_planes (.clk(clk), .pat(pat), .grp0(g0), .grp1(g1), .grp2(g2),
      .grp3(g3));
   pclut_top u_pclut_top (.clk(clk), .rst(rst), .host_sel(hsel), .host_wr(hwr),
      .host_rd(hrd), .host_wdata(wd), .host_wr_ready(wrdy), .host_rdata(rdata),
      .host_rvalid(rv), .plane_grp0(g0), .plane_grp1(g1), .plane_grp2(g2), .plane_grp3(g3),
      .shared_addr_bit_eight(b8), .shared_addr_bit_nine(b9), .cursor_in(cur),
      .text_overlay_in(txt), .ext_blank_in(blk), .mixed_sync_in(syn), .colour_out(colour),
      .red_out(r_o), .green_out(gr_o), .blue_out(b_o), .mixed_sync_out(so));
   initial forever #12.5 clk = ~clk;
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [15:0] act, input logic [15:0] exp, input string what);
      cmp_count++;
      if (act !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, act, exp);
      end
   endtask
   // Queued write; a spare edge between calls keeps the strobe single-driven
   task automatic wr(input logic sel, input logic [15:0] d);
      @(posedge clk);
      hsel <= sel;
      wd <= d;
      hwr <= 1'b1;
      do @(negedge clk); while (wrdy !== 1'b1);
      @(posedge clk);
      hwr <= 1'b0;
   endtask
   // Reads bypass the buffer, so let queued writes land first
   task automatic rd(input logic sel);
      repeat (6) @(posedge clk);
      hsel <= sel;
      hrd <= 1'b1;
      @(posedge clk);
      hrd <= 1'b0;
      @(negedge clk);
      chk({15'h0, rv}, 16'h1, "rvalid");
      got = rdata;
   endtask
   function automatic logic [7:0] grp(input logic [1:0] s, input logic [7:0] p);
      case (s)
         2'h0: return p;
         2'h1: return p ^ 8'hA5;
         2'h2: return ~p;
         default: return 8'hFF;
      endcase
   endfunction
   task automatic px(input logic [1:0] s, input logic c);
      logic [7:0] p;
      logic [1:0] hi;
      p = 8'($random(seed));
      hi = 2'($random(seed));
      @(posedge clk);
      pat <= p;
      {b9, b8} <= hi;
      cur <= c;
      syn <= 1'($random(seed));
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk({4'h0, colour}, {4'h0, shadow[{hi, grp(c ? 2'h3 : s, p)}]}, "pixel");
   endtask
   // Hang guard, well above the few thousand cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(SEL_ADDR_REG);
      chk(got, CTL_RESET, "ctl reset");
      wr(SEL_ADDR_REG, 16'hC000);
      for (i = 0; i < LUT_DEPTH; i++) begin
         shadow[i] = 12'($random(seed));
         wr(SEL_DATA_REG, {4'($random(seed)), shadow[i]});
      end
      rd(SEL_ADDR_REG);
      chk(got, 16'hC000, "up wrap");
      chk({4'h0, colour}, 16'h0000, "load blank");
      @(posedge clk);
      txt <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk({4'h0, colour}, {4'h0, COLOUR_WHITE}, "text white");
      @(posedge clk);
      txt <= 1'b0;
      $display("test fill done");
      shadow[1] = PEAK_BLUE;
      shadow[0] = PEAK_RED;
      wr(SEL_ADDR_REG, 16'h8001);
      wr(SEL_DATA_REG, {4'h0, PEAK_BLUE});
      wr(SEL_DATA_REG, {4'h0, PEAK_RED});
      rd(SEL_ADDR_REG);
      chk(got, 16'h83FF, "down wrap");
      wr(SEL_ADDR_REG, 16'h8001);
      rd(SEL_DATA_REG);
      rd(SEL_DATA_REG);
      chk(got, {4'h0, PEAK_BLUE}, "data read");
      rd(SEL_ADDR_REG);
      chk(got, 16'h8001, "read no step");
      $display("test direction done");
      // Overlay half filled with one colour, as software draws a cursor
      wr(SEL_ADDR_REG, 16'hC080);
      for (i = 128; i < 256; i++) begin
         shadow[i] = PEAK_RED;
         wr(SEL_DATA_REG, {4'h0, PEAK_RED});
      end
      $display("test overlay fill done");
      for (n = 0; n < NUM_GROUPS; n++) begin
         wr(SEL_ADDR_REG, {2'b00, 2'(n), 12'h000});
         repeat (3) px(2'(n), 1'b0);
         px(2'(n), 1'b1);
      end
      @(posedge clk);
      blk <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk({4'h0, colour}, 16'h0000, "ext blank");
      @(posedge clk);
      blk <= 1'b0;
      $display("test display done");
      // Held read stalls draining so the buffer must refuse
      n = 0;
      hsel <= SEL_ADDR_REG;
      wd <= 16'h0000;
      hrd <= 1'b1;
      hwr <= 1'b1;
      repeat (6) begin
         @(negedge clk);
         if (wrdy === 1'b1)
            n++;
      end
      @(posedge clk);
      hwr <= 1'b0;
      hrd <= 1'b0;
      chk(16'(n), 16'(WBUF_DEPTH), "buffer depth");
      rd(SEL_ADDR_REG);
      chk(got, 16'h0000, "drained");
      $display("test buffer done");
      give_verdict();
   end
endmodule // tb_pclut_top
bind pclut_top pclut_monitor u_pclut_monitor (.clk(clk), .rst(rst), .host_rd(host_rd),
   .host_rvalid(host_rvalid), .host_rdata(host_rdata), .host_wr_ready(host_wr_ready),
   .text_overlay_in(text_overlay_in), .ext_blank_in(ext_blank_in),
   .mixed_sync_in(mixed_sync_in), .mixed_sync_out(mixed_sync_out), .colour_out(colour_out),
   .red_out(red_out), .green_out(green_out), .blue_out(blue_out));
